// ---- hdl/stop_wake_pkg.sv ----
package stop_wake_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets in the core register file
	localparam logic [7:0] WAKE_TIMER_CONTROL_OFS = 8'h10;
	localparam logic [7:0] STOP_UNLOCK_OFS        = 8'hFB;

	// reset values
	localparam logic [7:0] WAKE_TIMER_CONTROL_RST = 8'h00;
	localparam logic [7:0] STOP_UNLOCK_RST        = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;

	// unlock pattern 1010_0101
	localparam logic [7:0] STOP_UNLOCK_PATTERN    = 8'hA5;

	// wake_timer_control field positions
	localparam int         WTC_ENABLE_BIT         = 7;
	localparam int         WTC_IRQ_ENABLE_BIT     = 5;
	localparam int         WTC_PRESCALE_LSB       = 0;
	localparam int         WTC_PRESCALE_W         = 4;

	// largest valid prescale selection and divider width
	localparam logic [3:0] PRESCALE_MAX           = 4'hC;
	localparam int         PRESCALE_CNT_W         = 12;

	////////////////////////////////////////////////////////////////////////////////
	// register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} reg_req_s;

	// state of the stop gate and control registers
	typedef struct packed {
		logic [7:0] stop_unlock;
		logic [7:0] wake_ctrl;
		logic [7:0] rdata;
		logic       stop_enter;
		logic       reset_load;
		logic       wake_irq;
	} gate_state_s;

	// state of the wake prescaler
	typedef struct packed {
		logic [PRESCALE_CNT_W-1:0] cnt;
		logic                      tick;
	} presc_state_s;

endpackage : stop_wake_pkg

// ---- hdl/wake_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none

module wake_prescaler
	import stop_wake_pkg::*;
#(
	parameter int CNT_W = PRESCALE_CNT_W
)
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_en,
	input  wire logic [3:0] i_sel,
	output logic            o_tick
);
	import stop_wake_pkg::*;

	presc_state_s st_reg;
	presc_state_s st_next;
	logic [CNT_W-1:0] mask;
	logic             match;

	////////////////////////////////////////////////////////////////////////////////
	// low-bit mask for a divide by 2^n; selections above the maximum are clamped
	function automatic logic [CNT_W-1:0] div_mask(input logic [3:0] sel);
		logic [3:0] n;
		n = (sel > PRESCALE_MAX) ? PRESCALE_MAX : sel;
		div_mask = CNT_W'((32'h1 << n) - 32'h1);
	endfunction : div_mask

	assign mask  = div_mask(i_sel);
	assign match = (st_reg.cnt & mask) == mask;

	always_comb
	begin
		st_next = st_reg;
		if (i_en)
		begin
			st_next.cnt  = st_reg.cnt + CNT_W'(1);
			st_next.tick = match;
		end
		else
		begin
			st_next.cnt  = '0;
			st_next.tick = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_tick = st_reg.tick;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_TICK_ON_MATCH:
		assert property (i_en && match |=> o_tick)
		else $error("wake tick missing at divider wrap");
	AST_DIV_TWO:
		assert property (i_en && i_sel == 4'h1 ##1 i_en && i_sel == 4'h1 && o_tick ##1 i_en && i_sel == 4'h1
			|-> !o_tick ##1 o_tick)
		else $error("divide by two tick spacing wrong");

endmodule : wake_prescaler

`default_nettype wire

// ---- hdl/stop_mode_wakeup_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

// How it works
// - The stop instruction takes effect only while the unlock register holds 8'hA5.
// - A stop issued with any other unlock value loads the reset address instead.
// - Bit 7 of the wake timer control register turns the wake timer on or off.
// - Bits 3..0 select N (values above 12 act as 12) and the wake timer clock is the system clock divided by 2^N.
module stop_mode_wakeup_timer
(
	input  wire logic                    i_clk,
	input  wire logic                    i_resetn,
	input  wire stop_wake_pkg::reg_req_s i_reg,
	input  wire logic                    i_stop_exec,
	input  wire logic                    i_wake_expire,
	output logic [7:0]                   o_rdata,
	output logic                         o_stop_enter,
	output logic                         o_reset_load,
	output logic                         o_wake_timer_en,
	output logic                         o_wake_tick,
	output logic                         o_wake_irq
);
	import stop_wake_pkg::*;

	logic        rst_meta_n;
	logic        rst_n;
	gate_state_s st_reg;
	gate_state_s st_next;
	logic        unlocked;
	logic        wr_unlock;
	logic        wr_ctrl;
	logic        en_reg;

	////////////////////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register decode
	function automatic logic hit(input reg_req_s req, input logic [7:0] ofs);
		hit = (req.addr == ofs);
	endfunction : hit

	assign unlocked  = (st_reg.stop_unlock == STOP_UNLOCK_PATTERN);
	assign wr_unlock = i_reg.wr && hit(i_reg, STOP_UNLOCK_OFS);
	assign wr_ctrl   = i_reg.wr && hit(i_reg, WAKE_TIMER_CONTROL_OFS);

	always_comb
	begin
		st_next = st_reg;
		if (wr_unlock)
			st_next.stop_unlock = i_reg.wdata;
		// bits 6 and 4 are stored as written; software keeps them zero
		if (wr_ctrl)
			st_next.wake_ctrl = i_reg.wdata;
		if (i_reg.rd && hit(i_reg, STOP_UNLOCK_OFS))
			st_next.rdata = st_reg.stop_unlock;
		else if (i_reg.rd && hit(i_reg, WAKE_TIMER_CONTROL_OFS))
			st_next.rdata = st_reg.wake_ctrl;
		else
			st_next.rdata = UNMAPPED_READ_VALUE;
		// the value stored before this cycle decides a stop in this cycle
		st_next.stop_enter = i_stop_exec && unlocked;
		st_next.reset_load = i_stop_exec && !unlocked;
		st_next.wake_irq   = i_wake_expire && st_reg.wake_ctrl[WTC_ENABLE_BIT]
			&& st_reg.wake_ctrl[WTC_IRQ_ENABLE_BIT];
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg             <= '0;
			st_reg.stop_unlock <= STOP_UNLOCK_RST;
			st_reg.wake_ctrl   <= WAKE_TIMER_CONTROL_RST;
			st_reg.rdata       <= UNMAPPED_READ_VALUE;
		end
		else
			st_reg <= st_next;
	end

	// enable copy kept as its own flip-flop so the output stays registered
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			en_reg <= 1'b0;
		else
			en_reg <= st_next.wake_ctrl[WTC_ENABLE_BIT];
	end

	////////////////////////////////////////////////////////////////////////////////
	// wake timer clock divider
	wake_prescaler #(
		.CNT_W (PRESCALE_CNT_W)
	) u_prescaler (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_en    (st_reg.wake_ctrl[WTC_ENABLE_BIT]),
		.i_sel   (st_reg.wake_ctrl[WTC_PRESCALE_LSB +: WTC_PRESCALE_W]),
		.o_tick  (o_wake_tick)
	);

	assign o_rdata         = st_reg.rdata;
	assign o_stop_enter    = st_reg.stop_enter;
	assign o_reset_load    = st_reg.reset_load;
	assign o_wake_timer_en = en_reg;
	assign o_wake_irq      = st_reg.wake_irq;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	AST_STOP_WHEN_UNLOCKED:
		assert property (i_stop_exec && st_reg.stop_unlock == 8'hA5 |=> o_stop_enter && !o_reset_load)
		else $error("stop not honoured with unlock pattern");
	AST_NO_STOP_WITHOUT_EXEC:
		assert property (!i_stop_exec |=> !o_stop_enter && !o_reset_load)
		else $error("stop outcome without a stop instruction");
	AST_RESET_WHEN_LOCKED:
		assert property (i_stop_exec && st_reg.stop_unlock != 8'hA5 |=> o_reset_load && !o_stop_enter)
		else $error("locked stop did not load the reset address");
	AST_UNLOCK_THEN_STOP:
		assert property (wr_unlock && i_reg.wdata == 8'hA5 && !i_reg.rd ##1 i_stop_exec && !wr_unlock
			|=> o_stop_enter)
		else $error("stop after unlock write refused");
	AST_DISABLED_NO_TICK:
		assert property (!o_wake_timer_en |=> !o_wake_tick)
		else $error("wake tick while timer disabled");
	AST_ENABLE_FOLLOWS_WRITE:
		assert property (wr_ctrl |=> o_wake_timer_en == $past(i_reg.wdata[7]))
		else $error("timer enable does not follow control write");
	AST_IRQ_GATED:
		assert property (!st_reg.wake_ctrl[5] |=> !o_wake_irq)
		else $error("wake interrupt while masked");
	AST_IRQ_RAISED:
		assert property (i_wake_expire && st_reg.wake_ctrl[7] && st_reg.wake_ctrl[5] |=> o_wake_irq)
		else $error("wake interrupt missing");
	AST_DIV_BY_ONE:
		assert property (o_wake_timer_en && st_reg.wake_ctrl[3:0] == 4'h0 && !wr_ctrl [*2] |-> ##1 o_wake_tick)
		else $error("divide by one does not tick every cycle");

	// stop gate outcome
	AST_ONE_OUTCOME:
		assert property (!(o_stop_enter && o_reset_load))
		else $error("stop granted and reset load together");
	AST_OUTCOME_PER_STOP:
		assert property (i_stop_exec |=> o_stop_enter != o_reset_load)
		else $error("stop instruction without exactly one outcome");
	AST_STOP_NEEDS_PATTERN:
		assert property (o_stop_enter |-> $past(st_reg.stop_unlock) == 8'hA5)
		else $error("stop granted without the unlock pattern");
	AST_RESET_NEEDS_LOCK:
		assert property (o_reset_load |-> $past(st_reg.stop_unlock) != 8'hA5)
		else $error("reset load although unlocked");

	// register file
	AST_UNLOCK_WRITE:
		assert property (wr_unlock |=> st_reg.stop_unlock == $past(i_reg.wdata))
		else $error("unlock register did not take the written value");
	AST_UNLOCK_HOLD:
		assert property (!wr_unlock |=> $stable(st_reg.stop_unlock))
		else $error("unlock register changed without a write");
	AST_CTRL_WRITE:
		assert property (wr_ctrl |=> st_reg.wake_ctrl == $past(i_reg.wdata))
		else $error("control register did not take the written value");
	AST_CTRL_HOLD:
		assert property (!wr_ctrl |=> $stable(st_reg.wake_ctrl))
		else $error("control register changed without a write");
	AST_READ_UNLOCK:
		assert property (i_reg.rd && i_reg.addr == 8'hFB |=> o_rdata == $past(st_reg.stop_unlock))
		else $error("unlock register read back wrong");
	AST_READ_CTRL:
		assert property (i_reg.rd && i_reg.addr == 8'h10 |=> o_rdata == $past(st_reg.wake_ctrl))
		else $error("control register read back wrong");

	// wake timer and interrupt
	AST_ENABLE_HOLDS:
		assert property (!wr_ctrl |=> $stable(o_wake_timer_en))
		else $error("timer enable changed without a write");
	AST_TICK_NEEDS_ENABLE:
		assert property (o_wake_tick |-> $past(o_wake_timer_en))
		else $error("wake tick without the timer enabled");
	AST_TICK_OFF_AFTER_DISABLE:
		assert property (wr_ctrl && !i_reg.wdata[7] |-> ##2 !o_wake_tick)
		else $error("wake tick after the timer was disabled");
	AST_TICK_SPACED:
		assert property (o_wake_timer_en && st_reg.wake_ctrl[3:0] != 4'h0 ##1 o_wake_timer_en && o_wake_tick
			&& $stable(st_reg.wake_ctrl[3:0]) |=> !o_wake_tick)
		else $error("wake tick longer than one cycle with a divider");
	AST_TICK_AT_WRAP:
		assert property (o_wake_timer_en && st_reg.wake_ctrl[3:0] == 4'h1 ##1 o_wake_timer_en
			&& st_reg.wake_ctrl[3:0] == 4'h1 && !o_wake_tick |=> o_wake_tick)
		else $error("divide by two skipped a tick");
	AST_IRQ_NEEDS_EXPIRE:
		assert property (!i_wake_expire |=> !o_wake_irq)
		else $error("wake interrupt without an expiry");
	AST_IRQ_NEEDS_TIMER:
		assert property (!st_reg.wake_ctrl[7] |=> !o_wake_irq)
		else $error("wake interrupt while the timer is off");

	COV_STOP_ENTER:  cover property (o_stop_enter);
	COV_RESET_LOAD:  cover property (o_reset_load);
	COV_WAKE_TICK:   cover property (o_wake_tick ##[2:20] o_wake_tick);
	COV_WAKE_IRQ:    cover property (o_wake_irq);
	COV_UNLOCK_STOP: cover property (wr_unlock ##1 i_stop_exec ##1 o_stop_enter);

endmodule : stop_mode_wakeup_timer

`default_nettype wire

// ---- verif/core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module core_model
	import stop_wake_pkg::*;
(
	input  wire logic                 i_clk,
	output stop_wake_pkg::reg_req_s   o_reg,
	output logic                      o_stop_exec
);
	initial
	begin
		o_reg = '0;
		o_stop_exec = 1'b0;
	end
	// one access; address and data scrambled while idle
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
		logic [7:0] v;
		v = d;
		if (w && a == WAKE_TIMER_CONTROL_OFS)
		begin
			v = v & 8'hAF;
			if (v[3:0] > PRESCALE_MAX)
				v[3:0] = PRESCALE_MAX;
		end
		@(posedge i_clk) #1;
		o_reg = '{addr: a, wr: w, rd: !w, wdata: w ? v : ~v};
		@(posedge i_clk) #1;
		o_reg = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~v};
	endtask : access
	task automatic stop();
		@(posedge i_clk) #1;
		o_stop_exec = 1'b1;
		@(posedge i_clk) #1;
		o_stop_exec = 1'b0;
	endtask : stop
endmodule : core_model
`default_nettype wire

// ---- verif/stop_mode_wakeup_timer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin bad_count++; \
	$display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module stop_mode_wakeup_timer_tb;
	import stop_wake_pkg::*;
	logic       clk, resetn, expire, stop_exec, stop_enter, reset_load, wt_en, tick, irq;
	reg_req_s   req;
	logic [7:0] rdata, v;
	int         bad_count, checks, seed, cyc, tcount, n;
	stop_mode_wakeup_timer dut (.i_clk(clk), .i_resetn(resetn), .i_reg(req), .i_stop_exec(stop_exec),
		.i_wake_expire(expire), .o_rdata(rdata), .o_stop_enter(stop_enter), .o_reset_load(reset_load),
		.o_wake_timer_en(wt_en), .o_wake_tick(tick), .o_wake_irq(irq));
	core_model core (.i_clk(clk), .o_reg(req), .o_stop_exec(stop_exec));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic end_sim;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	always @(posedge clk)
	begin
		tcount++;
		if (tcount == 100000)
		begin
			bad_count++;
			end_sim();
		end
	end
	// expected wake tick spacing for a prescale selection
	function automatic int tick_period(input int sel);
		tick_period = 1 << ((sel > int'(PRESCALE_MAX)) ? int'(PRESCALE_MAX) : sel);
	endfunction : tick_period
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
		core.access(a, 8'h00, 1'b0);
		`CHK("rdata", ex, rdata)
	endtask : rd_chk
	task automatic stop_chk(input logic go);
		core.stop();
		`CHK("stop_enter", go, stop_enter)
		`CHK("reset_load", !go, reset_load)
	endtask : stop_chk
	// cycles from the enabling write to the first tick, then tick to tick
	task automatic tick_chk(input int k);
		for (int j = 0; j < 2; j++)
		begin
			cyc = 0;
			do
			begin
				@(posedge clk) #1;
				cyc++;
			end while (tick !== 1'b1 && cyc < 5000);
			`CHK("tick_period", tick_period(k), cyc)
		end
	endtask : tick_chk
	task automatic expire_chk(input logic ex);
		@(posedge clk) #1;
		expire = 1'b1;
		@(posedge clk) #1;
		expire = 1'b0;
		`CHK("irq", ex, irq)
	endtask : expire_chk
	initial
	begin
		seed = 19;
		resetn = 1'b0;
		expire = 1'b0;
		repeat (6) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(WAKE_TIMER_CONTROL_OFS, WAKE_TIMER_CONTROL_RST);
		rd_chk(STOP_UNLOCK_OFS, STOP_UNLOCK_RST);
		rd_chk(8'h11, UNMAPPED_READ_VALUE);
		stop_chk(1'b0);
		for (int i = 0; i < 8; i++)
		begin
			v = (i == 0) ? 8'hA4 : (i == 1) ? 8'h25 : 8'($random(seed));
			if (v == STOP_UNLOCK_PATTERN)
				v = 8'hA7;
			core.access(STOP_UNLOCK_OFS, v, 1'b1);
			stop_chk(1'b0);
		end
		core.access(STOP_UNLOCK_OFS, STOP_UNLOCK_PATTERN, 1'b1);
		rd_chk(STOP_UNLOCK_OFS, STOP_UNLOCK_PATTERN);
		stop_chk(1'b1);
		stop_chk(1'b1);
		for (int i = 0; i < 8; i++)
		begin
			n = (i == 0) ? 0 : (i == 1) ? 12 : (i == 2) ? 1 : int'($unsigned($random(seed)) % 13);
			core.access(WAKE_TIMER_CONTROL_OFS, 8'h00, 1'b1);
			`CHK("timer_en", 1'b0, wt_en)
			@(posedge clk) #1;
			`CHK("tick_off", 1'b0, tick)
			core.access(WAKE_TIMER_CONTROL_OFS, 8'h80 | 8'(n), 1'b1);
			`CHK("timer_en", 1'b1, wt_en)
			tick_chk(n);
			rd_chk(WAKE_TIMER_CONTROL_OFS, 8'h80 | 8'(n));
		end
		core.access(WAKE_TIMER_CONTROL_OFS, 8'hA3, 1'b1);
		expire_chk(1'b1);
		core.access(WAKE_TIMER_CONTROL_OFS, 8'h83, 1'b1);
		expire_chk(1'b0);
		core.access(STOP_UNLOCK_OFS, 8'h00, 1'b1);
		stop_chk(1'b0);
		// reset in mid-run with the timer ticking and the gate unlocked
		core.access(STOP_UNLOCK_OFS, STOP_UNLOCK_PATTERN, 1'b1);
		core.access(WAKE_TIMER_CONTROL_OFS, 8'h80, 1'b1);
		@(posedge clk) #1 resetn = 1'b0;
		#1 `CHK("reset_timer_en", 1'b0, wt_en)
		`CHK("reset_tick", 1'b0, tick)
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(WAKE_TIMER_CONTROL_OFS, WAKE_TIMER_CONTROL_RST);
		stop_chk(1'b0);
		end_sim();
	end
endmodule : stop_mode_wakeup_timer_tb
`default_nettype wire
